// ### logic/reset_levels_params.svh
// Constants for the reset level sequencer and its pin timer
//
// Behaviour
// - Levels are strictly ordered and entering one asserts every lower level until run mode is reached.
// - The power-on level is entered on a power-on event, a software request or the reset pin low for over one second.
// - The power-on level clears shutdown memory, re-enables the reset pin and debug port, then moves to brownout.
// - The brownout level is entered on a power-on event, a brownout event in reset mode or on wake from shutdown.
// - The brownout level resets the power unit and core supply logic, then moves to the boot level.
// - The boot level is entered on brownout cascade, software, fatal clock failure or a short reset pin press.
// - The boot level runs the boot configuration routine and resets most core logic and configuration.
// - The boot level power-cycles the SRAM and then moves to the system level.
// - The system level is entered on boot cascade, boot loader entry or exit, watchdog, software or debug.
// - The system level resets processor and peripherals but leaves the clock and timekeeping domain alone.
// - Releasing the system level puts the device in run mode.
// - The processor-only level comes only from software or debug and touches processor logic alone.
// - The timekeeping domain is reset only by the boot, brownout or power-on levels.
// - A boot level caused by the reset pin or software keeps the timekeeping, clock and pin mux setup.
// - The brownout detector answers with a reset or an interrupt, at a selectable threshold.
// - Boot policies come from a dedicated flash region whose erased words mean the default values.
`ifndef RESET_LEVELS_PARAMS_SVH
`define RESET_LEVELS_PARAMS_SVH

// -------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------
`define CLK_HZ          32'h017D7840
`define PIN_LONG_S      32'h00000001
`define PIN_LONG_CYC    (`PIN_LONG_S * `CLK_HZ)
`define LEVEL_HOLD_CYC  4'h8

// -------------------------------------------------------------------
// Boot configuration region and brownout threshold reset value
// -------------------------------------------------------------------
`define CFG_WORDS       4
`define CFG_ERASED      32'hFFFFFFFF
`define BOR_THR_RESET   2'h0

`endif

// ### logic/reset_levels_pkg.sv
// Types shared by the reset level sequencer
package reset_levels_pkg;
  typedef enum logic [2:0] {
    st_run,
    st_por,
    st_bor,
    st_boot,
    st_sys,
    st_cpu
  } level_t;
endpackage

// ### logic/pin_timer_if.sv
// Carrier between the reset pin timer and the level sequencer
`timescale 1ns/1ps
interface pin_timer_if;
  logic pin_en;
  logic pin_short;
  logic pin_long;
  modport timer (input pin_en, output pin_short, output pin_long);
  modport seq   (output pin_en, input pin_short, input pin_long);
endinterface

// ### logic/reset_pin_timer.sv
// Low-time classifier for the external reset pin
`timescale 1ns/1ps
`include "reset_levels_params.svh"
module reset_pin_timer #(
  parameter int unsigned LONG_CYC = `PIN_LONG_CYC
) (
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  input  wire logic   external_reset_pin_n_in,
  pin_timer_if.timer  tif
);
  localparam int unsigned CW = $clog2(LONG_CYC + 1);

  logic [CW-1:0] low_cnt_r;
  logic          long_done_r;
  logic          short_r;
  logic          long_r;

  assign tif.pin_short = short_r;
  assign tif.pin_long  = long_r;

  // Only the block reset clears this timer; the levels it triggers do not
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      low_cnt_r   <= '0;
      long_done_r <= 1'b0;
      short_r     <= 1'b0;
      long_r      <= 1'b0;
    end else begin
      short_r <= 1'b0;
      long_r  <= 1'b0;
      if (!tif.pin_en || external_reset_pin_n_in) begin
        // Release decides a short press; a long one already fired
        short_r     <= tif.pin_en && (low_cnt_r != '0) && !long_done_r;
        low_cnt_r   <= '0;
        long_done_r <= 1'b0;
      end else if (!long_done_r) begin
        if (low_cnt_r == CW'(LONG_CYC)) begin
          long_r      <= 1'b1;
          long_done_r <= 1'b1;
        end else begin
          low_cnt_r <= low_cnt_r + CW'(1);
        end
      end
    end
  end
endmodule

// ### logic/reset_level_sequencer.sv
// Hierarchical reset level sequencer
`timescale 1ns/1ps
`include "reset_levels_params.svh"
module reset_level_sequencer #(
  parameter int unsigned PIN_LONG_CYC = `PIN_LONG_CYC,
  parameter int unsigned CFG_WORDS    = `CFG_WORDS,
  parameter int unsigned CFG_AW       = 4,
  parameter logic [CFG_WORDS*32-1:0] CFG_DEFAULTS = '0
) (
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    external_reset_pin_n_in,
  input  wire logic                    por_event_in,
  input  wire logic                    bor_event_in,
  input  wire logic                    shutdown_wake_in,
  input  wire logic                    sw_por_req_in,
  input  wire logic                    sw_boot_req_in,
  input  wire logic                    sw_sys_req_in,
  input  wire logic                    sw_cpu_req_in,
  input  wire logic                    clk_fail_in,
  input  wire logic                    wdt_timeout_in,
  input  wire logic                    debug_sys_req_in,
  input  wire logic                    debug_cpu_req_in,
  input  wire logic                    boot_loader_entry_in,
  input  wire logic                    boot_loader_exit_in,
  input  wire logic                    pin_debug_disable_in,
  input  wire logic                    bor_reset_mode_in,
  input  wire logic [1:0]              bor_threshold_in,
  input  wire logic [31:0]             cfg_rd_data_in,
  input  wire logic                    cfg_rd_valid_in,
  output logic                         por_level_out,
  output logic                         bor_level_out,
  output logic                         boot_level_reset_out,
  output logic                         system_level_reset_out,
  output logic                         processor_only_reset_out,
  output logic                         shutdown_mem_clear_out,
  output logic                         sram_power_cycle_out,
  output logic                         rtc_domain_reset_out,
  output logic                         pin_debug_enable_out,
  output logic                         run_mode_out,
  output logic                         bor_irq_out,
  output logic [1:0]                   bor_threshold_out,
  output logic                         cfg_rd_req_out,
  output logic [CFG_AW-1:0]            cfg_rd_addr_out,
  output logic [CFG_WORDS*32-1:0]      boot_policy_out,
  output logic [2:0]                   reset_cause_out
);
  // -----------------------------------------------------------------
  // Pin timer
  // -----------------------------------------------------------------
  pin_timer_if tif ();

  reset_pin_timer #(
    .LONG_CYC (PIN_LONG_CYC)
  ) u_pin_timer (
    .clk_in                  (clk_in),
    .sys_rst_in              (sys_rst_in),
    .external_reset_pin_n_in (external_reset_pin_n_in),
    .tif                     (tif.timer)
  );

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  reset_levels_pkg::level_t state_r;
  reset_levels_pkg::level_t state_nxt;
  reset_levels_pkg::level_t tgt;

  logic [3:0]        hold_r;
  logic [3:0]        hold_nxt;
  logic              rd_r;
  logic              rd_nxt;
  logic [CFG_AW-1:0] idx_r;
  logic [CFG_AW-1:0] idx_nxt;
  logic              boot_keep_r;
  logic              pin_dbg_en_r;
  logic              take;
  logic              hold_done;
  logic              cfg_take;
  logic              por_req;
  logic              bor_req;
  logic              boot_req;
  logic              sys_req;
  logic              cpu_req;
  logic [31:0]       policy_r [CFG_WORDS];

  assign tif.pin_en = pin_dbg_en_r;

  // -----------------------------------------------------------------
  // Request decode
  // -----------------------------------------------------------------
  // Brownout in interrupt mode raises no reset
  assign por_req  = por_event_in | sw_por_req_in | tif.pin_long;
  assign bor_req  = por_event_in | shutdown_wake_in
                  | (bor_event_in & bor_reset_mode_in);
  assign boot_req = sw_boot_req_in | clk_fail_in | tif.pin_short;
  assign sys_req  = boot_loader_entry_in | boot_loader_exit_in
                  | wdt_timeout_in | sw_sys_req_in
                  | debug_sys_req_in;
  assign cpu_req  = sw_cpu_req_in | debug_cpu_req_in;

  // Depth in the ladder; run sits below every level
  function automatic logic [2:0] depth(
    input reset_levels_pkg::level_t l
  );
    unique case (l)
      reset_levels_pkg::st_por:  depth = 3'h1;
      reset_levels_pkg::st_bor:  depth = 3'h2;
      reset_levels_pkg::st_boot: depth = 3'h3;
      reset_levels_pkg::st_sys:  depth = 3'h4;
      reset_levels_pkg::st_cpu:  depth = 3'h5;
      reset_levels_pkg::st_run:  depth = 3'h6;
    endcase
  endfunction

  always_comb begin
    tgt = reset_levels_pkg::st_run;
    if (por_req) begin
      tgt = reset_levels_pkg::st_por;
    end else if (bor_req) begin
      tgt = reset_levels_pkg::st_bor;
    end else if (boot_req) begin
      tgt = reset_levels_pkg::st_boot;
    end else if (sys_req) begin
      tgt = reset_levels_pkg::st_sys;
    end else if (cpu_req) begin
      tgt = reset_levels_pkg::st_cpu;
    end
  end

  // A request at or above the current level restarts there; lower
  // ones are absorbed because the cascade resets that logic anyway
  assign take = (tgt != reset_levels_pkg::st_run)
              && (depth(tgt) <= depth(state_r));
  assign hold_done = (hold_r == `LEVEL_HOLD_CYC - 4'h1);
  assign cfg_take  = rd_r && cfg_rd_valid_in
                   && (state_r == reset_levels_pkg::st_boot);

  // -----------------------------------------------------------------
  // Level ladder
  // -----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    hold_nxt  = hold_done ? hold_r : hold_r + 4'h1;
    rd_nxt    = rd_r;
    idx_nxt   = idx_r;
    if (take) begin
      state_nxt = tgt;
      hold_nxt  = 4'h0;
      rd_nxt    = 1'b0;
      idx_nxt   = '0;
    end else begin
      unique case (state_r)
        reset_levels_pkg::st_run: begin
          hold_nxt = 4'h0;
        end
        reset_levels_pkg::st_por: begin
          if (hold_done) begin
            state_nxt = reset_levels_pkg::st_bor;
            hold_nxt  = 4'h0;
          end
        end
        reset_levels_pkg::st_bor: begin
          if (hold_done) begin
            state_nxt = reset_levels_pkg::st_boot;
            hold_nxt  = 4'h0;
          end
        end
        reset_levels_pkg::st_boot: begin
          if (!rd_r && hold_done) begin
            rd_nxt = 1'b1;
          end else if (cfg_take) begin
            if (idx_r == CFG_AW'(CFG_WORDS - 1)) begin
              state_nxt = reset_levels_pkg::st_sys;
              hold_nxt  = 4'h0;
              rd_nxt    = 1'b0;
              idx_nxt   = '0;
            end else begin
              idx_nxt = idx_r + CFG_AW'(1);
            end
          end
        end
        reset_levels_pkg::st_sys: begin
          if (hold_done) begin
            state_nxt = reset_levels_pkg::st_run;
          end
        end
        reset_levels_pkg::st_cpu: begin
          if (hold_done) begin
            state_nxt = reset_levels_pkg::st_run;
          end
        end
      endcase
    end
  end

  // Block reset counts as a power-on, so the full ladder runs first
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= reset_levels_pkg::st_por;
      hold_r  <= 4'h0;
      rd_r    <= 1'b0;
      idx_r   <= '0;
    end else begin
      state_r <= state_nxt;
      hold_r  <= hold_nxt;
      rd_r    <= rd_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Boot cause and pin enable
  // -----------------------------------------------------------------
  // Cascade from brownout or a clock failure must not keep the setup
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      boot_keep_r <= 1'b0;
    end else if (take && tgt == reset_levels_pkg::st_boot) begin
      boot_keep_r <= (tif.pin_short | sw_boot_req_in)
                   & ~clk_fail_in;
    end else if (take && depth(tgt) < 3'h3) begin
      boot_keep_r <= 1'b0;
    end
  end

  // Re-enable wins over a disable landing in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_dbg_en_r <= 1'b1;
    end else if (state_nxt == reset_levels_pkg::st_por) begin
      pin_dbg_en_r <= 1'b1;
    end else if (pin_debug_disable_in) begin
      pin_dbg_en_r <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Boot policy store
  // -----------------------------------------------------------------
  // An erased word means the region was never reprogrammed
  for (genvar i = 0; i < CFG_WORDS; i++) begin : g_policy
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        policy_r[i] <= CFG_DEFAULTS[i*32 +: 32];
      end else if (cfg_take && idx_r == CFG_AW'(i)) begin
        policy_r[i] <= (cfg_rd_data_in == `CFG_ERASED)
                     ? CFG_DEFAULTS[i*32 +: 32]
                     : cfg_rd_data_in;
      end
    end
    assign boot_policy_out[i*32 +: 32] = policy_r[i];
  end

  // -----------------------------------------------------------------
  // Level outputs
  // -----------------------------------------------------------------
  // Outputs follow the next state so they change with the state flop
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      por_level_out            <= 1'b1;
      bor_level_out            <= 1'b1;
      boot_level_reset_out     <= 1'b1;
      system_level_reset_out   <= 1'b1;
      processor_only_reset_out <= 1'b1;
      shutdown_mem_clear_out   <= 1'b1;
      sram_power_cycle_out     <= 1'b1;
      rtc_domain_reset_out     <= 1'b1;
      run_mode_out             <= 1'b0;
    end else begin
      por_level_out   <= (depth(state_nxt) <= 3'h1);
      bor_level_out   <= (depth(state_nxt) <= 3'h2);
      boot_level_reset_out   <= (depth(state_nxt) <= 3'h3);
      system_level_reset_out <= (depth(state_nxt) <= 3'h4);
      processor_only_reset_out <= (depth(state_nxt) <= 3'h5);
      shutdown_mem_clear_out <= (state_nxt == reset_levels_pkg::st_por);
      sram_power_cycle_out <= (depth(state_nxt) <= 3'h3);
      rtc_domain_reset_out <= (depth(state_nxt) <= 3'h2)
        || (state_nxt == reset_levels_pkg::st_boot
            && !(take ? ((tif.pin_short | sw_boot_req_in)
                         & ~clk_fail_in)
                      : boot_keep_r));
      run_mode_out <= (state_nxt == reset_levels_pkg::st_run);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_debug_enable_out <= 1'b1;
      cfg_rd_req_out       <= 1'b0;
      cfg_rd_addr_out      <= '0;
    end else begin
      pin_debug_enable_out <= (state_nxt == reset_levels_pkg::st_por)
                            || (pin_dbg_en_r && !pin_debug_disable_in);
      cfg_rd_req_out       <= rd_nxt;
      cfg_rd_addr_out      <= idx_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Brownout configuration and cause
  // -----------------------------------------------------------------
  // Threshold only steers the analog detector; it is passed on flopped
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bor_irq_out       <= 1'b0;
      bor_threshold_out <= `BOR_THR_RESET;
      reset_cause_out   <= 3'h1;
    end else begin
      bor_irq_out <= bor_event_in & ~bor_reset_mode_in
                   & ~por_event_in;
      bor_threshold_out <= bor_threshold_in;
      if (take) begin
        reset_cause_out <= depth(tgt);
      end
    end
  end
endmodule

// ### verification/reset_levels_properties.sv
// Checker for the reset level sequencer ports
`timescale 1ns/1ps
module reset_levels_properties #(
  parameter int unsigned CFG_AW = 4
) (
  input wire logic              clk_in,
  input wire logic              sys_rst_in,
  input wire logic              por_event_in,
  input wire logic              bor_event_in,
  input wire logic              shutdown_wake_in,
  input wire logic              sw_por_req_in,
  input wire logic              sw_boot_req_in,
  input wire logic              sw_sys_req_in,
  input wire logic              sw_cpu_req_in,
  input wire logic              clk_fail_in,
  input wire logic              wdt_timeout_in,
  input wire logic              debug_cpu_req_in,
  input wire logic              bor_reset_mode_in,
  input wire logic              cfg_rd_valid_in,
  input wire logic              por_level_out,
  input wire logic              bor_level_out,
  input wire logic              boot_level_reset_out,
  input wire logic              system_level_reset_out,
  input wire logic              processor_only_reset_out,
  input wire logic              shutdown_mem_clear_out,
  input wire logic              sram_power_cycle_out,
  input wire logic              rtc_domain_reset_out,
  input wire logic              run_mode_out,
  input wire logic              bor_irq_out,
  input wire logic              cfg_rd_req_out,
  input wire logic [CFG_AW-1:0] cfg_rd_addr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // -----------------------------------------------------------------
  // Level ordering
  // -----------------------------------------------------------------
  AST_NEST: assert property (por_level_out <= bor_level_out
    && bor_level_out <= boot_level_reset_out
    && boot_level_reset_out <= system_level_reset_out
    && system_level_reset_out <= processor_only_reset_out)
    else $error("level nesting broken");
  AST_RUN: assert property (run_mode_out != processor_only_reset_out)
    else $error("run mode while a level is held");
  // A release must follow a full hold, not a shortened one
  AST_HOLD: assert property ($fell(system_level_reset_out) |->
    $past(system_level_reset_out, 8)) else $error("system level short");
  // -----------------------------------------------------------------
  // Entry causes
  // -----------------------------------------------------------------
  AST_POR: assert property ((por_event_in || sw_por_req_in) |=>
    por_level_out && shutdown_mem_clear_out) else $error("no power-on");
  AST_BOR: assert property ((bor_event_in && bor_reset_mode_in)
    || shutdown_wake_in |=> bor_level_out) else $error("no brownout");
  AST_IRQ: assert property (bor_event_in && !bor_reset_mode_in |=>
    bor_irq_out) else $error("no brownout interrupt");
  AST_BOOT: assert property ((sw_boot_req_in || clk_fail_in) |=>
    boot_level_reset_out && sram_power_cycle_out) else $error("no boot");
  AST_SYS: assert property ((wdt_timeout_in || sw_sys_req_in) |=>
    system_level_reset_out) else $error("no system level");
  AST_CPU: assert property ($rose(processor_only_reset_out)
    && !system_level_reset_out |-> $past(sw_cpu_req_in || debug_cpu_req_in))
    else $error("processor reset without cause");
  AST_SRAM: assert property (sram_power_cycle_out ==
    boot_level_reset_out) else $error("sram cycle mismatch");
  AST_RTC: assert property (bor_level_out <= rtc_domain_reset_out
    && rtc_domain_reset_out <= boot_level_reset_out)
    else $error("timekeeping reset at wrong level");
  AST_CLKF: assert property (clk_fail_in |=> rtc_domain_reset_out)
    else $error("clock failure kept timekeeping");
  // -----------------------------------------------------------------
  // Boot configuration reads
  // -----------------------------------------------------------------
  AST_CFG0: assert property ($rose(cfg_rd_req_out) |->
    cfg_rd_addr_out == '0) else $error("reads do not start at zero");
  AST_CFGH: assert property (cfg_rd_req_out && !cfg_rd_valid_in |=>
    cfg_rd_req_out && $stable(cfg_rd_addr_out))
    else $error("read request dropped before answer");
endmodule

bind reset_level_sequencer reset_levels_properties #(.CFG_AW(CFG_AW))
  i_reset_levels_properties (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .por_event_in(por_event_in), .bor_event_in(bor_event_in),
  .shutdown_wake_in(shutdown_wake_in), .sw_por_req_in(sw_por_req_in),
  .sw_boot_req_in(sw_boot_req_in), .sw_sys_req_in(sw_sys_req_in),
  .sw_cpu_req_in(sw_cpu_req_in), .clk_fail_in(clk_fail_in),
  .wdt_timeout_in(wdt_timeout_in), .debug_cpu_req_in(debug_cpu_req_in),
  .bor_reset_mode_in(bor_reset_mode_in), .cfg_rd_valid_in(cfg_rd_valid_in),
  .por_level_out(por_level_out), .bor_level_out(bor_level_out),
  .boot_level_reset_out(boot_level_reset_out),
  .system_level_reset_out(system_level_reset_out),
  .processor_only_reset_out(processor_only_reset_out),
  .shutdown_mem_clear_out(shutdown_mem_clear_out),
  .sram_power_cycle_out(sram_power_cycle_out),
  .rtc_domain_reset_out(rtc_domain_reset_out), .run_mode_out(run_mode_out),
  .bor_irq_out(bor_irq_out), .cfg_rd_req_out(cfg_rd_req_out),
  .cfg_rd_addr_out(cfg_rd_addr_out));

// ### verification/cfg_region_model.sv
// Behavioural model of the boot configuration flash region
`timescale 1ns/1ps
module cfg_region_model (
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        cfg_rd_req_in,
  input  wire logic [3:0]  cfg_rd_addr_in,
  output logic [31:0]      cfg_rd_data_out,
  output logic             cfg_rd_valid_out
);
  logic [1:0]  wait_r;
  logic [31:0] last_r;
  logic [31:0] word;
  // Word 2 is left erased so the default path is exercised
  assign word = (cfg_rd_addr_in == 4'h2) ? 32'hFFFFFFFF :
                {28'hC0DE000, cfg_rd_addr_in};
  assign cfg_rd_valid_out = cfg_rd_req_in && (wait_r >= {slow_in, 1'b0});
  // Between answers the bus shows junk, never the last word
  assign cfg_rd_data_out = cfg_rd_valid_out ? word : ~last_r;
  always_ff @(posedge clk_in) begin
    if (!cfg_rd_req_in || cfg_rd_valid_out) wait_r <= 2'h0;
    else if (wait_r != 2'h3) wait_r <= wait_r + 2'h1;
    if (cfg_rd_valid_out) last_r <= word;
  end
endmodule

// ### verification/hierarchical_reset_levels_tb.sv
// Self-checking bench for the reset level sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module hierarchical_reset_levels_tb;
  localparam int unsigned LONG = 20;
  logic clk_in = 0, sys_rst_in = 1, pin_n = 1, pdis = 0, bmode = 1, slow = 1;
  logic [1:0]   thr = 2'h0, thr_o;
  logic [12:0]  req = '0;
  logic [31:0]  cfg_data;
  logic [3:0]   cfg_addr;
  logic [127:0] policy;
  logic [2:0]   cause;
  logic cfg_valid, cfg_req, por_l, bor_l, boot_l, sys_l, cpu_l;
  logic memclr, sram, rtc, pen, run, irq;
  int n_fail = 0, samples_checked = 0, cyc = 0, k;
  wire [4:0] lvl = {por_l, bor_l, boot_l, sys_l, cpu_l};
  reset_level_sequencer #(.PIN_LONG_CYC(LONG)) i_reset_level_sequencer (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .external_reset_pin_n_in(pin_n), .por_event_in(req[0]),
    .bor_event_in(req[1]), .shutdown_wake_in(req[2]),
    .sw_por_req_in(req[3]), .sw_boot_req_in(req[4]), .sw_sys_req_in(req[5]),
    .sw_cpu_req_in(req[6]), .clk_fail_in(req[7]), .wdt_timeout_in(req[8]),
    .debug_sys_req_in(req[9]), .debug_cpu_req_in(req[10]),
    .boot_loader_entry_in(req[11]), .boot_loader_exit_in(req[12]),
    .pin_debug_disable_in(pdis), .bor_reset_mode_in(bmode),
    .bor_threshold_in(thr), .cfg_rd_data_in(cfg_data),
    .cfg_rd_valid_in(cfg_valid), .por_level_out(por_l),
    .bor_level_out(bor_l), .boot_level_reset_out(boot_l),
    .system_level_reset_out(sys_l), .processor_only_reset_out(cpu_l),
    .shutdown_mem_clear_out(memclr), .sram_power_cycle_out(sram),
    .rtc_domain_reset_out(rtc), .pin_debug_enable_out(pen),
    .run_mode_out(run), .bor_irq_out(irq), .bor_threshold_out(thr_o),
    .cfg_rd_req_out(cfg_req), .cfg_rd_addr_out(cfg_addr),
    .boot_policy_out(policy), .reset_cause_out(cause));
  cfg_region_model i_cfg_region_model (.clk_in(clk_in), .slow_in(slow),
    .cfg_rd_req_in(cfg_req), .cfg_rd_addr_in(cfg_addr),
    .cfg_rd_data_out(cfg_data), .cfg_rd_valid_out(cfg_valid));
  initial forever #20 clk_in = ~clk_in;
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One-cycle request, called and returning at a falling edge
  task automatic fire(input int b);
    req[b] = 1'b1;
    @(negedge clk_in);
    req[b] = 1'b0;
  endtask
  task automatic wait_run;
    k = 0;
    while (run !== 1'b1 && k < 300) begin
      @(negedge clk_in);
      k++;
    end
    `CHK("run", 1'b1, run)
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_ladder;
    `CHK("ladder", 5'h1F, lvl)
    `CHK("memclr", 1'b1, memclr)
    wait_run();
    `CHK("levels", 5'h00, lvl)
    `CHK("policy", {32'hC0DE0003, 32'h0, 32'hC0DE0001, 32'hC0DE0000},
      policy)
  endtask
  task automatic t_sys;
    int src[5] = '{5, 8, 9, 11, 12};
    slow = 1'b0;
    foreach (src[i]) begin
      fire(src[i]);
      `CHK("sys", 5'h03, lvl)
      `CHK("cause", 3'h4, cause)
      `CHK("sys_run", 1'b0, run)
      repeat (7) @(negedge clk_in);
      `CHK("sys_hold", 1'b1, sys_l)
      @(negedge clk_in);
      `CHK("sys_end", 1'b1, run)
    end
  endtask
  task automatic t_cpu;
    fire(6);
    `CHK("cpu_sw", 5'h01, lvl)
    `CHK("cpu_cause", 3'h5, cause)
    wait_run();
    fire(10);
    `CHK("cpu_dbg", 5'h01, lvl)
    wait_run();
  endtask
  task automatic t_boot;
    fire(4);
    `CHK("boot_sw", 5'h07, lvl)
    `CHK("rtc_keep", 1'b0, rtc)
    wait_run();
    slow = 1'b1;
    fire(7);
    `CHK("boot_cf", 5'h07, lvl)
    `CHK("rtc_cf", 1'b1, rtc)
    `CHK("sram", 1'b1, sram)
    wait_run();
    `CHK("policy2", 32'hC0DE0003, policy[127:96])
  endtask
  task automatic t_bor;
    bmode = 1'b0;
    fire(1);
    `CHK("irq", 1'b1, irq)
    `CHK("irq_lvl", 5'h00, lvl)
    bmode = 1'b1;
    @(negedge clk_in);
    fire(1);
    `CHK("bor", 5'h0F, lvl)
    `CHK("bor_rtc", 1'b1, rtc)
    `CHK("bor_mem", 1'b0, memclr)
    wait_run();
    fire(2);
    `CHK("wake", 5'h0F, lvl)
    wait_run();
    thr = 2'h3;
    repeat (2) @(negedge clk_in);
    `CHK("thr", 2'h3, thr_o)
  endtask
  task automatic t_por;
    pdis = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK("pin_off", 1'b0, pen)
    fire(3);
    `CHK("por_sw", 5'h1F, lvl)
    `CHK("por_cause", 3'h1, cause)
    `CHK("por_mem", 1'b1, memclr)
    `CHK("pin_on", 1'b1, pen)
    pdis = 1'b0;
    wait_run();
    fire(0);
    `CHK("por_ev", 5'h1F, lvl)
    wait_run();
  endtask
  task automatic t_pin;
    pin_n = 1'b0;
    repeat (5) @(negedge clk_in);
    pin_n = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK("pin_short", 5'h07, lvl)
    `CHK("pin_rtc", 1'b0, rtc)
    wait_run();
    pin_n = 1'b0;
    repeat (LONG + 6) @(negedge clk_in);
    `CHK("pin_long", 1'b1, por_l)
    pin_n = 1'b1;
    wait_run();
    // A disabled pin must not disturb a running device
    pdis = 1'b1;
    repeat (2) @(negedge clk_in);
    pin_n = 1'b0;
    repeat (5) @(negedge clk_in);
    pin_n = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK("pin_dis", 1'b1, run)
    pdis = 1'b0;
  endtask
  // -------------------------------------------------------------------
  // Main sequence and hang guard
  // -------------------------------------------------------------------
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    t_ladder();
    t_sys();
    t_cpu();
    t_boot();
    t_bor();
    t_por();
    t_pin();
    test_done();
  end
endmodule
